// ### common/uart_host_defines.vh
// Constants for the quad UART host bus port controller
`ifndef UART_HOST_DEFINES_VH
`define UART_HOST_DEFINES_VH

// Strobe timing in clock cycles at 10 MHz
`define CLOCK_PERIOD_NS      100
`define SETUP_TIME_NS        100
`define SETUP_CYCLES         ((`SETUP_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define STROBE_TIME_NS       300
`define STROBE_CYCLES        ((`STROBE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define HOLD_TIME_NS         100
`define HOLD_CYCLES          ((`HOLD_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define COUNT_WIDTH          4
// Extra strobe cycles so read data crosses the two-flop sync
`define SYNC_CYCLES          2

// Bus widths
`define DATA_WIDTH           8
`define REG_ADDR_WIDTH       3
`define CHAN_WIDTH           2

// Sequencer states
`define ST_IDLE              3'h0
`define ST_SETUP             3'h1
`define ST_STROBE            3'h2
`define ST_HOLD              3'h3
`define ST_DONE              3'h4

`endif

// ### rtl/pin_sync.v
// Two-flop synchroniser for a single level from outside the clock domain
`timescale 1ns/1ps

module pin_sync #(
    parameter RESET_VALUE = 1'b0
) (
    // Clock and reset
    input  wire clock,
    input  wire rst_n,
    // Level in and out
    input  wire din,
    output reg  dout
);

    reg stage;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage <= RESET_VALUE;
            dout  <= RESET_VALUE;
        end else begin
            stage <= din;
            dout  <= stage;
        end
    end

endmodule // pin_sync

// ### rtl/quad_uart_host_bus_port.v
// Host controller driving the quad UART parallel bus in strobe or select style
//
// Overview of operation
// (RULE1) Mode pin high: separate strobes, per-channel selects
// (RULE2) Three register address lines pick register
// (RULE3) Eight-bit bidirectional data, driven only on writes
// (RULE4) Read strobe falling edge starts device read
// (RULE5) Host captures read byte at strobe rise
// (RULE6) Write strobe falling edge starts device write
// (RULE7) Device latches write byte at strobe rise
// (RULE8) Each chip select enables only its channel
// (RULE9) Select style: direction line high reads
// (RULE10) Select style: one chip select for device
// (RULE11) Select style: channel B select is A3
// (RULE12) Select style: channel C select is A4
// (RULE13) Select style: read strobe held high
// (RULE14) Select style: channel D select held high
// (RULE15) Select style: channel A irq is device irq
// (RULE16) Select style: other irq pins stay low
// (RULE17) A4:A3 codes 00..11 pick channels A..D
// (RULE18) Data bus released outside valid writes
`timescale 1ns/1ps
`include "uart_host_defines.vh"

module quad_uart_host_bus_port (
    // Clock and reset
    input  wire                         clock,
    input  wire                         nrst,
    // User command port
    input  wire                         strobe_style,
    input  wire                         req_valid,
    output wire                         req_ready,
    input  wire                         req_write,
    input  wire [`CHAN_WIDTH-1:0]       req_channel,
    input  wire [`REG_ADDR_WIDTH-1:0]   req_addr,
    input  wire [`DATA_WIDTH-1:0]       req_wdata,
    output reg                          rsp_valid,
    output reg  [`DATA_WIDTH-1:0]       rsp_rdata,
    // Interrupt status seen from the device
    output wire [3:0]                   irq_pending,
    // Device bus pins
    output reg                          bus_style,
    output reg  [`REG_ADDR_WIDTH-1:0]   reg_addr,
    input  wire [`DATA_WIDTH-1:0]       data_in,
    output reg  [`DATA_WIDTH-1:0]       data_out,
    output reg                          data_oe,
    output reg                          read_strobe_n,
    output reg                          write_strobe_n,
    output reg                          chan_a_select_n,
    output reg                          chan_b_select_n,
    output reg                          chan_c_select_n,
    output reg                          chan_d_select_n,
    // Device interrupt pins
    input  wire                         chan_a_irq_out,
    input  wire                         chan_b_irq,
    input  wire                         chan_c_irq,
    input  wire                         chan_d_irq
);

    // ****************************************
    // Reset release and input synchronisers
    // ****************************************
    reg rst_meta;
    reg rst_n;

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    wire [`DATA_WIDTH-1:0] data_sync;
    wire [3:0]             irq_sync;
    wire [3:0]             irq_raw = {chan_d_irq, chan_c_irq, chan_b_irq, chan_a_irq_out};

    genvar i;
    generate
        for (i = 0; i < `DATA_WIDTH; i = i + 1) begin : g_data_sync
            pin_sync #(.RESET_VALUE(1'b0)) u_sync (
                .clock (clock),
                .rst_n (rst_n),
                .din   (data_in[i]),
                .dout  (data_sync[i])
            );
        end
        for (i = 0; i < 4; i = i + 1) begin : g_irq_sync
            pin_sync #(.RESET_VALUE(1'b0)) u_sync (
                .clock (clock),
                .rst_n (rst_n),
                .din   (irq_raw[i]),
                .dout  (irq_sync[i])
            );
        end
    endgenerate

    // Select style: one active-low device irq, others unused
    assign irq_pending = bus_style ? irq_sync : {3'h0, ~irq_sync[0]}; // see (RULE15) (RULE16)

    // ****************************************
    // Access sequencer
    // ****************************************
    localparam ST_IDLE   = `ST_IDLE;
    localparam ST_SETUP  = `ST_SETUP;
    localparam ST_STROBE = `ST_STROBE;
    localparam ST_HOLD   = `ST_HOLD;
    localparam ST_DONE   = `ST_DONE;

    localparam integer SETUP_LOAD  = `SETUP_CYCLES;
    localparam integer STROBE_LOAD = `STROBE_CYCLES + `SYNC_CYCLES;
    localparam integer HOLD_LOAD   = `HOLD_CYCLES;

    reg [2:0]              state;
    reg [`COUNT_WIDTH-1:0] count;
    reg                    is_write;
    reg [`CHAN_WIDTH-1:0]  channel;

    assign req_ready = (state == ST_IDLE);

    // Per-channel select decode for strobe style
    function [3:0] one_cold;
        input [`CHAN_WIDTH-1:0] ch;
        begin
            one_cold = 4'hF;
            one_cold[ch] = 1'b0;
        end
    endfunction

    // Drive selects and strobes for the active access
    task drive_select;
        input active;
        input strobe;
        reg [3:0] sel;
        begin
            sel = one_cold(channel);
            if (bus_style) begin
                {chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n} <=
                    active ? sel : 4'hF; // see (RULE1) (RULE8)
                read_strobe_n  <= ~(strobe & ~is_write); // see (RULE4)
                write_strobe_n <= ~(strobe & is_write); // see (RULE6)
            end else begin
                chan_a_select_n <= ~(active & strobe); // see (RULE10)
                chan_b_select_n <= channel[0]; // see (RULE11) (RULE17)
                chan_c_select_n <= channel[1]; // see (RULE12) (RULE17)
                chan_d_select_n <= 1'b1; // see (RULE14)
                read_strobe_n   <= 1'b1; // see (RULE13)
                // Back to read level when idle, so a style change makes no strobe edge
                write_strobe_n  <= ~(active & is_write); // see (RULE9)
            end
        end
    endtask

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state           <= ST_IDLE;
            count           <= {`COUNT_WIDTH{1'b0}};
            is_write        <= 1'b0;
            channel         <= {`CHAN_WIDTH{1'b0}};
            bus_style       <= 1'b1;
            reg_addr        <= {`REG_ADDR_WIDTH{1'b0}};
            data_out        <= {`DATA_WIDTH{1'b0}};
            data_oe         <= 1'b0;
            read_strobe_n   <= 1'b1;
            write_strobe_n  <= 1'b1;
            chan_a_select_n <= 1'b1;
            chan_b_select_n <= 1'b1;
            chan_c_select_n <= 1'b1;
            chan_d_select_n <= 1'b1;
            rsp_valid       <= 1'b0;
            rsp_rdata       <= {`DATA_WIDTH{1'b0}};
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req_valid) begin
                        bus_style <= strobe_style; // see (RULE1)
                        is_write  <= req_write;
                        channel   <= req_channel;
                        reg_addr  <= req_addr; // see (RULE2)
                        data_out  <= req_wdata;
                        data_oe   <= req_write; // see (RULE3) (RULE18)
                        count     <= SETUP_LOAD[`COUNT_WIDTH-1:0];
                        state     <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // Address, direction and channel settle before strobe
                    drive_select(1'b1, 1'b0);
                    if (count <= `COUNT_WIDTH'h1) begin
                        count <= STROBE_LOAD[`COUNT_WIDTH-1:0];
                        state <= ST_STROBE;
                    end else begin
                        count <= count - `COUNT_WIDTH'h1;
                    end
                end
                ST_STROBE: begin
                    // Strobe held long enough for the data to cross the sync
                    drive_select(1'b1, 1'b1);
                    if (count <= `COUNT_WIDTH'h1) begin
                        if (!is_write) begin
                            rsp_rdata <= data_sync; // see (RULE5)
                        end
                        count <= HOLD_LOAD[`COUNT_WIDTH-1:0];
                        state <= ST_HOLD;
                    end else begin
                        count <= count - `COUNT_WIDTH'h1;
                    end
                end
                ST_HOLD: begin
                    // Strobe rises; write data still driven for hold
                    drive_select(1'b1, 1'b0); // see (RULE7)
                    if (count <= `COUNT_WIDTH'h1) begin
                        state <= ST_DONE;
                    end else begin
                        count <= count - `COUNT_WIDTH'h1;
                    end
                end
                ST_DONE: begin
                    drive_select(1'b0, 1'b0);
                    data_oe   <= 1'b0; // see (RULE18)
                    rsp_valid <= 1'b1;
                    state     <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // quad_uart_host_bus_port

// ### testbench/quad_uart_host_bus_port_properties.sv
// Concurrent checks on the host bus port pins
`timescale 1ns/1ps
module quad_uart_host_bus_port_properties (
    // Clock and reset
    input wire logic       clock,
    input wire logic       nrst,
    // User side
    input wire logic       strobe_style,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic       req_write,
    input wire logic [1:0] req_channel,
    input wire logic [2:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic       rsp_valid,
    // Device pins
    input wire logic       bus_style,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic       chan_a_select_n,
    input wire logic       chan_b_select_n,
    input wire logic       chan_c_select_n,
    input wire logic       chan_d_select_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    wire take = req_valid && req_ready;
    wire [3:0] sel_n = {chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n};
    wire read_phase = !read_strobe_n || (!bus_style && write_strobe_n && !chan_a_select_n);
    sequence low_pulse(s);
        (!s)[*5] ##1 s;
    endsequence
    sequence select_pins;
        sel_n[2:1] == $past(req_channel, 3) && write_strobe_n == !$past(req_write, 3);
    endsequence
    sequence select_access;
        low_pulse(chan_a_select_n) and select_pins;
    endsequence
    a_rsp_after_take: assert property (take |-> ##9 rsp_valid)
        else $error("response pulse missing");
    a_write_pulse: assert property (take && strobe_style && req_write |-> ##3 low_pulse(write_strobe_n))
        else $error("write strobe pulse wrong");
    a_read_pulse: assert property (take && strobe_style && !req_write |-> ##3 low_pulse(read_strobe_n))
        else $error("read strobe pulse wrong");
    a_select_single: assert property (bus_style && !(read_strobe_n && write_strobe_n) |-> $onehot(~sel_n))
        else $error("not exactly one channel select");
    a_no_read_drive: assert property (read_phase |-> !data_oe)
        else $error("data bus driven during read");
    a_select_idle: assert property (!bus_style |-> read_strobe_n && chan_d_select_n)
        else $error("unused pins not high");
    a_select_channel: assert property (take && !strobe_style |-> ##3 select_access)
        else $error("select style pins wrong");
    a_addr_data: assert property (take |-> ##3 reg_addr == $past(req_addr, 3) && data_oe == $past(req_write, 3)
        && (!data_oe || data_out == $past(req_wdata, 3)))
        else $error("address or write data wrong");
endmodule // quad_uart_host_bus_port_properties

bind quad_uart_host_bus_port quad_uart_host_bus_port_properties i_props (.clock(clock), .nrst(nrst),
    .strobe_style(strobe_style), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_channel(req_channel), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .bus_style(bus_style), .reg_addr(reg_addr), .data_out(data_out), .data_oe(data_oe),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .chan_a_select_n(chan_a_select_n),
    .chan_b_select_n(chan_b_select_n), .chan_c_select_n(chan_c_select_n), .chan_d_select_n(chan_d_select_n));

// ### testbench/uart_device_model.sv
// Behavioural quad UART device on the far side of the host bus
`timescale 1ns/1ps
module uart_device_model (
    // Host bus pins
    input  wire logic       bus_style,
    input  wire logic [2:0] reg_addr,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic [3:0] sel_n,
    input  wire logic [7:0] data_out,
    output var  logic [7:0] data_in,
    // Interrupt sources and pins
    input  wire logic [3:0] irq_lvl,
    output wire logic [3:0] irq_pin
);
    logic [7:0] mem [0:31];
    logic [7:0] last = 8'h00;
    wire [1:0] ch = !bus_style ? sel_n[2:1] : !sel_n[1] ? 2'h1 : !sel_n[2] ? 2'h2 : !sel_n[3] ? 2'h3 : 2'h0;
    wire sel = bus_style ? !(&sel_n) : !sel_n[0];
    wire rd = sel && (bus_style ? !read_strobe_n : write_strobe_n);
    // Released bus shows the inverse of the last byte
    assign data_in = rd ? mem[{ch, reg_addr}] : ~last;
    always @* if (rd) last = mem[{ch, reg_addr}];
    always @(posedge write_strobe_n) if (bus_style && sel) mem[{ch, reg_addr}] <= data_out;
    always @(posedge sel_n[0]) if (!bus_style && !write_strobe_n) mem[{ch, reg_addr}] <= data_out;
    assign irq_pin = bus_style ? irq_lvl : {3'h0, ~|irq_lvl};
endmodule // uart_device_model

// ### testbench/quad_uart_host_bus_port_tb_top.sv
// Self-checking bench for the quad UART host bus port
`timescale 1ns/1ps
module quad_uart_host_bus_port_tb_top;
    logic clock = 0, nrst = 0, strobe_style = 1, req_valid = 0, req_write = 0;
    logic [1:0] req_channel = 0;
    logic [2:0] req_addr = 0;
    logic [7:0] req_wdata = 0;
    logic [3:0] irq_lvl = 0;
    wire req_ready, rsp_valid, bus_style, data_oe, read_strobe_n, write_strobe_n;
    wire [7:0] rsp_rdata, data_in, data_out;
    wire [2:0] reg_addr;
    wire [3:0] irq_pending, sel_n, irq_pin;
    int fail_count = 0, num_checks = 0, cycles = 0;
    logic [7:0] exp_mem [0:31];
    logic [8:0] exp_q [$];
    logic [8:0] e;
    initial forever #50 clock = ~clock;
    quad_uart_host_bus_port i_quad_uart_host_bus_port (.clock(clock), .nrst(nrst), .strobe_style(strobe_style),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_channel(req_channel),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .irq_pending(irq_pending), .bus_style(bus_style), .reg_addr(reg_addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .chan_a_select_n(sel_n[0]), .chan_b_select_n(sel_n[1]), .chan_c_select_n(sel_n[2]),
        .chan_d_select_n(sel_n[3]), .chan_a_irq_out(irq_pin[0]), .chan_b_irq(irq_pin[1]),
        .chan_c_irq(irq_pin[2]), .chan_d_irq(irq_pin[3]));
    uart_device_model i_uart_device_model (.bus_style(bus_style), .reg_addr(reg_addr),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .sel_n(sel_n), .data_out(data_out),
        .data_in(data_in), .irq_lvl(irq_lvl), .irq_pin(irq_pin));
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One access; expectation queued, held until taken
    task automatic acc(input logic st, input logic wr, input logic [1:0] ch, input logic [2:0] a,
                       input logic [7:0] d);
        @(posedge clock);
        strobe_style <= st;
        req_valid <= 1'b1;
        req_write <= wr;
        req_channel <= ch;
        req_addr <= a;
        req_wdata <= d;
        if (wr) exp_mem[{ch, a}] = d;
        exp_q.push_back({!wr, exp_mem[{ch, a}]});
        do @(posedge clock); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
        if (rsp_valid === 1'b1) begin
            e = exp_q.pop_front();
            if (e[8]) check("rsp_rdata", rsp_rdata, e[7:0]);
        end
    end
    initial begin
        logic [31:0] r;
        void'($urandom(98914));
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 32; i++) begin
            r = $urandom;
            acc(r[0], 1'b1, i[4:3], i[2:0], r[15:8]);
        end
        for (int i = 0; i < 80; i++) begin
            r = $urandom;
            acc(r[0], r[1], r[3:2], r[6:4], r[14:7]);
            if (r[15]) begin
                irq_lvl <= r[19:16];
                repeat (4) @(posedge clock);
                check("irq_pending", {4'h0, irq_pending}, {4'h0, r[0] ? r[19:16] : {3'h0, |r[19:16]}});
            end
        end
        repeat (12) @(posedge clock);
        check("queue", 8'(exp_q.size()), 8'h00);
        summarize();
    end
endmodule // quad_uart_host_bus_port_tb_top
